// file: eai_area_decode.sv
/*
 Address to area decode and external space check.
 Assumes a 24-bit byte address and ranges inside areas 0, 1 and 5.
*/
`timescale 1ns/1ps
`include "eai_consts.svh"
module eai_area_decode
   import eai_pkg::*;
#(
   parameter logic [23:0] ROM_END = `EAI_ROM_END,
   parameter logic [23:0] RAM_BASE = `EAI_RAM_BASE,
   parameter logic [23:0] RAM_END = `EAI_RAM_END,
   parameter logic [23:0] PROH_BASE = `EAI_PROH_BASE,
   parameter logic [23:0] PROH_END = `EAI_PROH_END
)
(
   input wire logic [23:0] addr,
   input eai_cfg_s cfg,
   output logic [2:0] area,
   output logic external
);

   logic in_rom;
   logic in_ram;
   logic in_proh;

   // Internal ranges carve holes out of the external areas
   always_comb begin
      area = addr[`EAI_AREA_HI:`EAI_AREA_LO];
      in_rom = cfg.rom_enable && area <= `EAI_AREA1 && addr <= ROM_END;  // [R9] [R16]
      in_ram = cfg.onchip_ram_enable && area == `EAI_AREA5 && addr >= RAM_BASE && addr <= RAM_END;  // [R17]
      in_proh = area == `EAI_AREA5 && addr >= PROH_BASE && addr <= PROH_END;  // [R18]
      external = cfg.ext_mode && area <= `EAI_LAST_AREA && !in_rom && !in_ram && !in_proh;  // [R16] [R18]
   end

endmodule : eai_area_decode

// file: eai_consts.svh
/*
 Named constants of the external area interface select block.
 Assumes inclusion by its bare name from design files.
*/
`ifndef EAI_CONSTS_SVH
`define EAI_CONSTS_SVH

// Area number field of a 24-bit byte address (2 Mbyte areas)
`define EAI_AREA_HI 23
`define EAI_AREA_LO 21
`define EAI_LAST_AREA 3'd5
`define EAI_AREA0 3'd0
`define EAI_AREA1 3'd1
`define EAI_AREA2 3'd2
`define EAI_AREA3 3'd3
`define EAI_AREA4 3'd4
`define EAI_AREA5 3'd5

// Default internal address ranges
`define EAI_ROM_END 24'h0fffff
`define EAI_RAM_BASE 24'hbf0000
`define EAI_RAM_END 24'hbfffff
`define EAI_PROH_BASE 24'hbe0000
`define EAI_PROH_END 24'hbeffff

// Remaining counts for a 2 or 3 state address phase
`define EAI_TMA_SHORT 6'h01
`define EAI_TMA_LONG 6'h02
`define EAI_ONE6 6'h01
`define EAI_PAD3 3'h0

// Idle (negated) levels of the active-low outputs
`define EAI_CS_OFF 6'h3f
`define EAI_DACK_OFF 4'hf

`endif

// file: eai_ext_model.sv
/*
 External device model that answers on the wait pin.
 Assumes the access sequencer's active-low chip selects, sampled on mclk.
*/
`timescale 1ns/1ps
module eai_ext_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [5:0] area_chip_select_n,
   input wire logic [7:0] wait_len,
   output logic wait_n
);
   logic [7:0] cnt_q;

   // Hold wait low for wait_len states once selected; pull-up level otherwise
   always_ff @(posedge mclk) begin
      if (srst || area_chip_select_n == 6'h3f) begin
         cnt_q <= 8'h00;
         wait_n <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         wait_n <= !(cnt_q < wait_len);
      end
   end
endmodule : eai_ext_model

// file: eai_if_select.sv
/*
 Per-area interface kind selection from the select bits.
 Assumes the area number comes from the address decode.
*/
`timescale 1ns/1ps
`include "eai_consts.svh"
module eai_if_select
   import eai_pkg::*;
(
   input eai_cfg_s cfg,
   input wire logic [2:0] area,
   output eai_if_e if_sel
);

   // Two-bit select; the forbidden pair falls back to basic
   function automatic eai_if_e pick(input logic alt_bit, input logic sram_bit, input eai_if_e alt_if);
      case ({alt_bit, sram_bit})
         2'b00: pick = if_basic;
         2'b01: pick = if_bsram;
         2'b10: pick = alt_if;
         default: pick = if_basic;  // [R21]
      endcase
   endfunction : pick

   // Area to interface kind
   always_comb begin
      case (area)
         `EAI_AREA0: if_sel = pick(cfg.area0_page_rom_sel, cfg.area0_byte_sram_sel, if_burst);  // [R10]
         `EAI_AREA1: if_sel = pick(cfg.area1_page_rom_sel, cfg.area1_byte_sram_sel, if_burst);  // [R11]
         `EAI_AREA2: if_sel = pick(1'b0, cfg.area2_byte_sram_sel, if_basic);  // [R13]
         `EAI_AREA3: if_sel = pick(cfg.area3_mux_enable, cfg.area3_byte_sram_sel, if_mux);  // [R14]
         `EAI_AREA4: if_sel = pick(cfg.area4_mux_enable, cfg.area4_byte_sram_sel, if_mux);  // [R15]
         `EAI_AREA5: if_sel = pick(cfg.area5_mux_enable, cfg.area5_byte_sram_sel, if_mux);  // [R19] [R20]
         default: if_sel = if_basic;
      endcase
   end

endmodule : eai_if_select

// file: eai_pkg.sv
/*
 Types of the external area interface select block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eai_pkg;

   // Interface kinds an area can take
   typedef enum logic [1:0] {if_basic, if_bsram, if_burst, if_mux} eai_if_e;

   // Access cycle states
   typedef enum logic [3:0] {
      st_idle, st_addr, st_hold, st_t1, st_t2, st_pwait, st_pinw, st_t3, st_tail, st_burst
   } eai_state_e;

   // Loose configuration bits, held by the owner of the control registers
   typedef struct packed {
      logic ext_mode;
      logic rom_enable;
      logic onchip_ram_enable;
      logic area0_page_rom_sel;
      logic area1_page_rom_sel;
      logic area0_byte_sram_sel;
      logic area1_byte_sram_sel;
      logic area2_byte_sram_sel;
      logic area3_byte_sram_sel;
      logic area4_byte_sram_sel;
      logic area5_byte_sram_sel;
      logic area3_mux_enable;
      logic area4_mux_enable;
      logic area5_mux_enable;
      logic addr_phase_extend;
      logic [5:0] three_state;
      logic [5:0][2:0] prog_wait;
      logic [5:0] cs_hold;
      logic [5:0] cs_tail;
      logic [2:0] burst_len;
      logic rd_late_negate;
      logic dack_extend;
      logic wait_enable;
   } eai_cfg_s;

   // One access request from an internal bus master
   typedef struct packed {
      logic [23:0] addr;
      logic write;
      logic dma_single;
      logic [1:0] dma_chan;
      logic [5:0] burst_count;
   } eai_req_s;

endpackage : eai_pkg

// file: eai_top.sv
/*
 External area access sequencer: picks the interface of the addressed
 area, drives chip selects and strobes, and counts the access states.
 Assumes synchronous inputs on mclk and a stable configuration during an access.
*/
`timescale 1ns/1ps
`include "eai_consts.svh"
// Notes on behaviour
// R1 - Mux data phase equals basic access states
// R2 - Mux address phase two or three states
// R3 - Mux total: address, data, waits, extensions
// R4 - Burst ROM: 0-63 bursts of 1-8 states
// R5 - Wait pin stretches access without limit
// R6 - Read strobe negate timing is adjustable
// R7 - Optional chip select extension states
// R8 - Transfer acknowledge timing is adjustable
// R9 - Area 0 external except enabled ROM
// R10 - Area 0 select: basic, SRAM, burst
// R11 - Area 1 uses same select encoding
// R12 - One active-low chip select per area
// R13 - Area 2: basic or byte SRAM only
// R14 - Area 3 select: basic, SRAM, mux
// R15 - Area 4 uses same select encoding
// R16 - Areas 1-4 external, area 1 ROM excepted
// R17 - RAM enable keeps RAM range internal
// R18 - Area 5 external except RAM, prohibited
// R19 - Area 5 picks basic, SRAM or mux
// R20 - Area 5 encoding matches areas 3, 4
// R21 - Forbidden select pair falls back basic
module eai_top
   import eai_pkg::*;
#(
   parameter int CYC_W = 12,
   parameter logic [23:0] ROM_END = `EAI_ROM_END,
   parameter logic [23:0] RAM_BASE = `EAI_RAM_BASE,
   parameter logic [23:0] RAM_END = `EAI_RAM_END,
   parameter logic [23:0] PROH_BASE = `EAI_PROH_BASE,
   parameter logic [23:0] PROH_END = `EAI_PROH_END
)
(
   input wire logic mclk,
   input wire logic srst,
   input eai_cfg_s cfg,
   input wire logic req_valid,
   input eai_req_s req,
   input wire logic wait_n,
   output logic req_ready,
   output logic internal_ack,
   output logic [5:0] area_chip_select_n,
   output logic rd_n,
   output logic wr_n,
   output logic addr_strobe_n,
   output logic [3:0] transfer_ack_outputs_n,
   output logic busy,
   output logic access_done,
   output logic [CYC_W-1:0] access_cycles,
   output eai_if_e if_active,
   output logic pin_wait_state,
   output logic burst_state
);

   eai_state_e state_q, state_d;
   eai_state_e data_end;
   logic [5:0] cnt_q, cnt_d;
   logic [5:0] bursts_q, bursts_d;
   logic [CYC_W-1:0] cyc_q, cyc_d;
   logic [2:0] area_q, area_d;
   eai_if_e if_q, if_d;
   logic write_q, write_d;
   logic dma_q, dma_d;
   logic [1:0] chan_q, chan_d;

   logic ready_q, ready_d;
   logic int_q, int_d;
   logic [5:0] cs_n_q, cs_n_d;
   logic rd_n_q, rd_n_d;
   logic wr_n_q, wr_n_d;
   logic as_n_q, as_n_d;
   logic [3:0] dack_n_q, dack_n_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic [CYC_W-1:0] acyc_q, acyc_d;
   eai_if_e ifo_q, ifo_d;
   logic tw_q, tw_d;
   logic tb_q, tb_d;

   logic [2:0] dec_area;
   logic dec_ext;
   eai_if_e dec_if;
   logic start;
   logic wait_active;

   // Area decode and interface selection of the requested address
   eai_area_decode #(
      .ROM_END(ROM_END),
      .RAM_BASE(RAM_BASE),
      .RAM_END(RAM_END),
      .PROH_BASE(PROH_BASE),
      .PROH_END(PROH_END)
   ) u_dec (
      .addr(req.addr),
      .cfg(cfg),
      .area(dec_area),
      .external(dec_ext)
   );

   eai_if_select u_sel (
      .cfg(cfg),
      .area(dec_area),
      .if_sel(dec_if)
   );

   // Decrement shared by the phase and burst counters
   function automatic logic [5:0] dec6(input logic [5:0] v);
      dec6 = v - `EAI_ONE6;
   endfunction : dec6

   // Cycle counter that sticks at its top rather than wrapping
   function automatic logic [CYC_W-1:0] sat_inc(input logic [CYC_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction : sat_inc

   // First state of the data phase, with optional hold extension
   function automatic eai_state_e entry(input logic hold);
      entry = hold ? st_hold : st_t1;  // [R7]
   endfunction : entry

   // Pin wait or last data state after the programmed waits
   function automatic eai_state_e after_wait(input logic waiting);
      after_wait = waiting ? st_pinw : st_t3;  // [R5]
   endfunction : after_wait

   // Strobe window of the data phase
   function automatic logic in_data(input eai_state_e s);
      in_data = s inside {st_t1, st_t2, st_pwait, st_pinw, st_t3};
   endfunction : in_data

   assign start = req_valid && state_q == st_idle && dec_ext;  // [R9] [R16] [R18]
   assign wait_active = cfg.wait_enable && !wait_n;

   // Where the data phase goes when it ends
   always_comb begin
      if (if_q == if_burst && bursts_q != '0) begin
         data_end = st_burst;  // [R4]
      end else if (if_q != if_burst && cfg.cs_tail[area_q]) begin
         data_end = st_tail;  // [R7]
      end else begin
         data_end = st_idle;
      end
   end

   // Access sequencer next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bursts_d = bursts_q;
      area_d = area_q;
      if_d = if_q;
      write_d = write_q;
      dma_d = dma_q;
      chan_d = chan_q;
      cyc_d = (state_q == st_idle) ? '0 : sat_inc(cyc_q);  // [R3]
      case (state_q)
         st_idle: begin
            if (start) begin
               area_d = dec_area;
               if_d = dec_if;
               write_d = req.write;
               dma_d = req.dma_single;
               chan_d = req.dma_chan;
               bursts_d = req.burst_count;
               cyc_d = sat_inc('0);
               if (dec_if == if_mux) begin
                  state_d = st_addr;
                  cnt_d = cfg.addr_phase_extend ? `EAI_TMA_LONG : `EAI_TMA_SHORT;  // [R2]
               end else begin
                  state_d = entry(cfg.cs_hold[dec_area]);
               end
            end
         end
         st_addr: begin
            if (cnt_q == '0) begin
               state_d = entry(cfg.cs_hold[area_q]);  // [R1]
            end else begin
               cnt_d = dec6(cnt_q);
            end
         end
         st_hold: begin
            state_d = st_t1;
         end
         st_t1: begin
            state_d = st_t2;
         end
         st_t2: begin
            if (!cfg.three_state[area_q]) begin
               state_d = data_end;
            end else if (cfg.prog_wait[area_q] != '0) begin
               state_d = st_pwait;
               cnt_d = dec6({`EAI_PAD3, cfg.prog_wait[area_q]});  // [R3]
            end else begin
               state_d = after_wait(wait_active);
            end
         end
         st_pwait: begin
            if (cnt_q == '0) begin
               state_d = after_wait(wait_active);
            end else begin
               cnt_d = dec6(cnt_q);
            end
         end
         st_pinw: begin
            state_d = after_wait(wait_active);  // [R5]
         end
         st_t3: begin
            state_d = data_end;
         end
         st_tail: begin
            state_d = st_idle;
         end
         st_burst: begin
            if (cnt_q == '0) begin
               bursts_d = dec6(bursts_q);
               if (bursts_q == `EAI_ONE6) begin
                  state_d = st_idle;
               end else begin
                  cnt_d = {`EAI_PAD3, cfg.burst_len};  // [R4]
               end
            end else begin
               cnt_d = dec6(cnt_q);
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
      // Load the burst length on entry from the full access
      if (state_d == st_burst && state_q != st_burst) begin
         cnt_d = {`EAI_PAD3, cfg.burst_len};  // [R4]
      end
   end

   // Sequencer registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= st_idle;
         cnt_q <= '0;
         bursts_q <= '0;
         cyc_q <= '0;
         area_q <= '0;
         if_q <= if_basic;
         write_q <= 1'b0;
         dma_q <= 1'b0;
         chan_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bursts_q <= bursts_d;
         cyc_q <= cyc_d;
         area_q <= area_d;
         if_q <= if_d;
         write_q <= write_d;
         dma_q <= dma_d;
         chan_q <= chan_d;
      end
   end

   // Pin and status values for the coming state
   always_comb begin
      ready_d = state_d == st_idle;
      int_d = req_valid && state_q == st_idle && !dec_ext;  // [R17]
      cs_n_d = `EAI_CS_OFF;
      if (state_d != st_idle) begin
         cs_n_d[area_d] = 1'b0;  // [R12]
      end
      rd_n_d = !(!write_d && (in_data(state_d) || state_d == st_burst ||
                (state_d == st_tail && cfg.rd_late_negate)));  // [R6]
      wr_n_d = !(write_d && state_d inside {st_t2, st_pwait, st_pinw, st_t3});
      as_n_d = state_d != st_addr;
      dack_n_d = `EAI_DACK_OFF;
      if (dma_d && (in_data(state_d) || (cfg.dack_extend && state_d inside {st_hold, st_tail}))) begin
         dack_n_d[chan_d] = 1'b0;  // [R8]
      end
      busy_d = state_d != st_idle;
      done_d = state_q != st_idle && state_d == st_idle;
      acyc_d = done_d ? cyc_q : acyc_q;  // [R3]
      ifo_d = if_d;
      tw_d = state_d == st_pinw;
      tb_d = state_d == st_burst;
   end

   // Output registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         ready_q <= 1'b1;
         int_q <= 1'b0;
         cs_n_q <= `EAI_CS_OFF;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         as_n_q <= 1'b1;
         dack_n_q <= `EAI_DACK_OFF;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         acyc_q <= '0;
         ifo_q <= if_basic;
         tw_q <= 1'b0;
         tb_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
         int_q <= int_d;
         cs_n_q <= cs_n_d;
         rd_n_q <= rd_n_d;
         wr_n_q <= wr_n_d;
         as_n_q <= as_n_d;
         dack_n_q <= dack_n_d;
         busy_q <= busy_d;
         done_q <= done_d;
         acyc_q <= acyc_d;
         ifo_q <= ifo_d;
         tw_q <= tw_d;
         tb_q <= tb_d;
      end
   end

   assign req_ready = ready_q;
   assign internal_ack = int_q;
   assign area_chip_select_n = cs_n_q;
   assign rd_n = rd_n_q;
   assign wr_n = wr_n_q;
   assign addr_strobe_n = as_n_q;
   assign transfer_ack_outputs_n = dack_n_q;
   assign busy = busy_q;
   assign access_done = done_q;
   assign access_cycles = acyc_q;
   assign if_active = ifo_q;
   assign pin_wait_state = tw_q;
   assign burst_state = tb_q;

   // Checks on the sequencer
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   a_mux_addr_short: assert property (  // [R2]
      start && dec_if == if_mux && !cfg.addr_phase_extend |=>
      (state_q == st_addr) [*2] ##1 state_q != st_addr)
      else $error("short mux address phase not two states");

   a_mux_addr_long: assert property (  // [R2]
      start && dec_if == if_mux && cfg.addr_phase_extend |=>
      (state_q == st_addr) [*3] ##1 state_q != st_addr)
      else $error("long mux address phase not three states");

   a_mux_data_phase: assert property (  // [R1]
      state_q == st_addr && cnt_q == '0 |=>
      (state_q == st_hold && cfg.cs_hold[area_q]) || (state_q == st_t1 && !cfg.cs_hold[area_q]))
      else $error("mux data phase does not start like a basic access");

   a_prog_wait_two: assert property (  // [R3]
      state_q == st_t2 && cfg.three_state[area_q] && cfg.prog_wait[area_q] == 3'h2 |=>
      (state_q == st_pwait) [*2] ##1 state_q != st_pwait)
      else $error("two programmed waits not inserted");

   a_pin_wait_hold: assert property (  // [R5]
      state_q == st_pinw && wait_active |=> state_q == st_pinw ##0 pin_wait_state)
      else $error("pin wait released while wait pin held");

   a_cs_follows: assert property (  // [R12]
      state_q != st_idle |-> !area_chip_select_n[area_q] && $countones(~area_chip_select_n) == 1)
      else $error("chip select does not match active area");

   a_burst_last: assert property (  // [R4]
      state_q == st_burst && cnt_q == '0 && bursts_q == `EAI_ONE6 |=> state_q == st_idle && access_done)
      else $error("last burst did not end the access");

   a_prohib_basic: assert property (  // [R21]
      dec_area == `EAI_AREA3 && cfg.area3_mux_enable && cfg.area3_byte_sram_sel |-> dec_if == if_basic)
      else $error("forbidden select pair not basic");

   a_ram_internal: assert property (  // [R17]
      req_valid && state_q == st_idle && cfg.onchip_ram_enable && req.addr >= RAM_BASE &&
      req.addr <= RAM_END |=> internal_ack && !busy)
      else $error("enabled RAM range went external");

   a_rd_late: assert property (  // [R6]
      state_q == st_tail && !write_q && cfg.rd_late_negate |-> !rd_n ##1 rd_n)
      else $error("late read negate not applied");

endmodule : eai_top

// file: eai_top_tb.sv
/*
 Self-checking bench of the access sequencer.
 Assumes the wait model beside it and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module eai_top_tb;
   import eai_pkg::*;
   logic mclk, srst, req_valid, wait_n, req_ready, internal_ack, rd_n, wr_n;
   logic addr_strobe_n, busy, access_done, pin_wait_state, burst_state, got_int;
   eai_cfg_s cfg;
   eai_req_s req;
   logic [5:0] area_chip_select_n;
   logic [5:0] exp_cs;
   logic [3:0] transfer_ack_outputs_n;
   logic [11:0] access_cycles;
   logic [7:0] wait_len;
   eai_if_e if_active;
   int err_count, check_count, tick, n_cs, n_rd, n_as, n_ack, n_pw, n_bs, n_wr, n_bz;
   int bcs[3] = '{2, 63, 0};
   int lens[3] = '{1, 7, 3};
   // Address, rom on, ram on, extended mode, expected internal
   logic [27:0] dec[10] = '{{24'h100000, 4'b1011}, {24'h100000, 4'b0010}, {24'h27fff0, 4'b1011},
      {24'h280000, 4'b1010}, {24'hbf0010, 4'b0111}, {24'hbf0010, 4'b0010}, {24'hbe0010, 4'b0011},
      {24'ha00000, 4'b0010}, {24'h400000, 4'b0001}, {24'hc00000, 4'b0011}};

   eai_top #(.ROM_END(24'h27ffff)) uut (.mclk(mclk), .srst(srst), .cfg(cfg), .req_valid(req_valid),
      .req(req), .wait_n(wait_n), .req_ready(req_ready), .internal_ack(internal_ack),
      .area_chip_select_n(area_chip_select_n), .rd_n(rd_n), .wr_n(wr_n), .addr_strobe_n(addr_strobe_n),
      .transfer_ack_outputs_n(transfer_ack_outputs_n), .busy(busy), .access_done(access_done),
      .access_cycles(access_cycles), .if_active(if_active), .pin_wait_state(pin_wait_state),
      .burst_state(burst_state));

   eai_ext_model ext (.mclk(mclk), .srst(srst), .area_chip_select_n(area_chip_select_n),
      .wait_len(wait_len), .wait_n(wait_n));

   // Clock, 20 ns period
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Hang guard
   always @(posedge mclk) begin
      tick++;
      if (tick == 20000) begin
         err_count++;
         close_out();
      end
   end

   task automatic close_out();
      $display("Checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (e !== g) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   // One request; counts output states until done or internal answer
   task automatic go();
      int k;
      k = 0;
      got_int = 1'b0;
      {n_cs, n_rd, n_as, n_ack, n_pw, n_bs, n_wr, n_bz} = '0;
      while (req_ready !== 1'b1 && k < 100) begin
         @(negedge mclk);
         k++;
      end
      // A request that never gets taken counts as a mismatch
      if (k >= 100) err_count++;
      req_valid = 1'b1;
      @(negedge mclk);
      req_valid = 1'b0;
      k = 0;
      while (access_done !== 1'b1 && !got_int && k < 2000) begin
         if (internal_ack === 1'b1) got_int = 1'b1;
         n_cs += (area_chip_select_n === exp_cs);
         n_rd += (rd_n === 1'b0);
         n_as += (addr_strobe_n === 1'b0);
         n_ack += (transfer_ack_outputs_n === 4'hb);
         n_pw += (pin_wait_state === 1'b1);
         n_bs += (burst_state === 1'b1);
         n_wr += (wr_n === 1'b0);
         n_bz += (busy === 1'b1);
         @(negedge mclk);
         k++;
      end
      // An access that never ends counts as a mismatch
      if (k >= 2000) err_count++;
   endtask : go

   // Clears every select bit, then sets the pair of one area
   task automatic set_sel(input int a, input logic hi, input logic lo);
      {cfg.area0_page_rom_sel, cfg.area1_page_rom_sel, cfg.area3_mux_enable} = 3'h0;
      {cfg.area4_mux_enable, cfg.area5_mux_enable, cfg.area0_byte_sram_sel} = 3'h0;
      {cfg.area1_byte_sram_sel, cfg.area2_byte_sram_sel, cfg.area3_byte_sram_sel} = 3'h0;
      {cfg.area4_byte_sram_sel, cfg.area5_byte_sram_sel} = 2'h0;
      case (a)
         0: {cfg.area0_page_rom_sel, cfg.area0_byte_sram_sel} = {hi, lo};
         1: {cfg.area1_page_rom_sel, cfg.area1_byte_sram_sel} = {hi, lo};
         2: cfg.area2_byte_sram_sel = lo;
         3: {cfg.area3_mux_enable, cfg.area3_byte_sram_sel} = {hi, lo};
         4: {cfg.area4_mux_enable, cfg.area4_byte_sram_sel} = {hi, lo};
         default: {cfg.area5_mux_enable, cfg.area5_byte_sram_sel} = {hi, lo};
      endcase
   endtask : set_sel

   function automatic eai_if_e exp_if(input int a, input int c);
      if (c == 1 || (a == 2 && c == 3)) return if_bsram;
      if (c == 2 && a < 2) return if_burst;
      if (c == 2 && a > 2) return if_mux;
      return if_basic;
   endfunction : exp_if

   // Main sequence
   initial begin
      eai_if_e e;
      {srst, req_valid, tick, err_count, check_count} = {2'b10, 96'h0};
      cfg = '0;
      req = '0;
      wait_len = 8'h00;
      {cfg.ext_mode, cfg.onchip_ram_enable, cfg.wait_enable} = 3'b111;
      exp_cs = 6'h3f;
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      chk("req_ready", 1, req_ready);
      chk("cs_n", 6'h3f, area_chip_select_n);
      for (int a = 0; a < 6; a++) begin
         for (int c = 0; c < 4; c++) begin
            set_sel(a, c[1], c[0]);
            e = exp_if(a, c);
            exp_cs = ~(6'h01 << a);
            req.addr = {a[2:0], 21'h000100};
            go();
            chk("if_active", e, if_active);
            chk("cs_states", (e == if_mux) ? 4 : 2, n_cs);
         end
      end
      set_sel(0, 1'b0, 1'b0);
      for (int i = 0; i < 10; i++) begin
         {req.addr, cfg.rom_enable, cfg.onchip_ram_enable, cfg.ext_mode} = dec[i][27:1];
         go();
         chk("internal", dec[i][0], got_int);
      end
      {cfg.onchip_ram_enable, cfg.ext_mode, cfg.three_state} = {2'b11, 6'h3f};
      set_sel(3, 1'b1, 1'b0);
      for (int i = 0; i < 2; i++) begin
         {cfg.addr_phase_extend, cfg.cs_hold[3], cfg.cs_tail[3]} = {3{i[0]}};
         cfg.prog_wait[3] = i[0] ? 3'h2 : 3'h0;
         exp_cs = 6'h37;
         req.addr = 24'h600000;
         go();
         chk("mux_cycles", i ? 10 : 5, access_cycles);
         chk("addr_states", 2 + i, n_as);
         chk("mux_cs_states", i ? 10 : 5, n_cs);
      end
      set_sel(2, 1'b0, 1'b0);
      {cfg.cs_hold[2], cfg.cs_tail[2], cfg.prog_wait[2]} = 5'b11011;
      {req.dma_single, req.dma_chan} = 3'b110;
      for (int i = 0; i < 2; i++) begin
         {cfg.rd_late_negate, cfg.dack_extend} = {2{i[0]}};
         exp_cs = 6'h3b;
         req.addr = 24'h400000;
         go();
         chk("basic_cycles", 8, access_cycles);
         chk("rd_states", 6 + i, n_rd);
         chk("dack_states", 6 + 2 * i, n_ack);
      end
      {cfg.cs_hold[2], cfg.cs_tail[2], cfg.prog_wait[2], req.dma_single} = 6'h00;
      for (int i = 0; i < 3; i++) begin
         cfg.wait_enable = (i != 1);
         wait_len = (i == 2) ? 8'h00 : 8'h05;
         req.write = (i == 1);
         go();
         chk("wait_cycles", (i == 0) ? 8 : 3, access_cycles);
         chk("wait_states", (i == 0) ? 5 : 0, n_pw);
         chk("busy_states", (i == 0) ? 8 : 3, n_bz);
         chk("wr_states", (i == 1) ? 2 : 0, n_wr);
         chk("rd_states_wr", (i == 1) ? 0 : 3 + 5 * (i == 0), n_rd);
      end
      {wait_len, cfg.three_state} = 14'h0;
      set_sel(0, 1'b1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         cfg.burst_len = lens[i][2:0];
         {req.addr, req.burst_count} = {24'h000100, bcs[i][5:0]};
         go();
         chk("burst_cycles", 2 + bcs[i] * (lens[i] + 1), access_cycles);
         chk("burst_states", bcs[i] * (lens[i] + 1), n_bs);
      end
      close_out();
   end
endmodule : eai_top_tb
